// [pkg/osab_defs.vh]
// constants for the oscillator band autoselect block
`ifndef OSAB_DEFS_VH
`define OSAB_DEFS_VH
// register word offsets (word addresses, one per bus word)
`define OSAB_ADDR_OSC      4'h0
`define OSAB_ADDR_PLL      4'h1
`define OSAB_ADDR_DIVLO    4'h2
`define OSAB_ADDR_CTRL     4'h3
`define OSAB_ADDR_TEST     4'h4
`define OSAB_ADDR_XDIV     4'h5
`define OSAB_ADDR_STAT1    4'h6
`define OSAB_ADDR_STAT2    4'h7
`define OSAB_ADDR_DIVREF   4'h8
`define OSAB_ADDR_DIVHI    4'h9
// oscillator register fields
`define OSAB_OSC_CORE_HI   7
`define OSAB_OSC_CORE_LO   6
`define OSAB_OSC_SUB_HI    5
`define OSAB_OSC_SUB_LO    3
`define OSAB_OSC_ADE       2
`define OSAB_OSC_ADL       1
// pll register fields
`define OSAB_PLL_VAS       7
`define OSAB_PLL_CPS       6
`define OSAB_PLL_CP_HI     5
`define OSAB_PLL_CP_LO     4
// control register fields
`define OSAB_CTRL_EPD      7
`define OSAB_CTRL_INJECTION_SIDE_SELECT     6
`define OSAB_CTRL_MOD      5
`define OSAB_CTRL_PD_HI    2
`define OSAB_CTRL_PD_LO    0
// test register fields
`define OSAB_TEST_D_HI     7
`define OSAB_TEST_D_LO     5
`define OSAB_TEST_FILTER_TRIM_SOURCE     3
`define OSAB_TEST_TUN_HI   2
`define OSAB_TEST_TUN_LO   0
// crystal divide register field
`define OSAB_XDIV_QUADRATURE_DISABLE     0
// reset values
`define OSAB_RST_OSC       8'h00
`define OSAB_RST_PLL       8'h00
`define OSAB_RST_CTRL      8'h40
`define OSAB_RST_TEST      8'h08
`define OSAB_RST_XDIV      8'h00
`define OSAB_RST_DIVREF    8'h38
`define OSAB_RST_DIVHI     8'h53
`define OSAB_RST_DIVLO     8'hf8
// detector voltage mode code
`define OSAB_DIAG_VOLT     3'h4
// adc code bands
`define OSAB_ADC_VAS_LO    3'h2
`define OSAB_ADC_VAS_HI    3'h5
`define OSAB_ADC_MIN       3'h0
`define OSAB_ADC_MAX       3'h7
`define OSAB_ADC_CP01      3'h3
`define OSAB_ADC_CP10      3'h4
// lock classes
`define OSAB_LOCK_OUT      2'h0
`define OSAB_LOCK_LOCKED   2'h1
`define OSAB_LOCK_VAS      2'h2
// pump settings
`define OSAB_CP_00         2'h0
`define OSAB_CP_01         2'h1
`define OSAB_CP_10         2'h2
`define OSAB_CP_11         2'h3
// settle wait per step, in clock cycles (stands for the loop time constant)
`define OSAB_SETTLE_CYC    8'h10
`define OSAB_STEPS_MAX     6'h20
`endif

// [logic/osab_adc_class.v]
// adc code to lock class and automatic pump setting
`timescale 1ns/1ps
`include "osab_defs.vh"
module osab_adc_class
(
    input  wire [2:0] code_in,
    output reg  [1:0] lock_class_out,
    output reg  [1:0] pump_auto_out
);
    // lock class from code
    always @*
    begin
        if (code_in == `OSAB_ADC_MIN || code_in == `OSAB_ADC_MAX)
            lock_class_out = `OSAB_LOCK_OUT;
        else if (code_in >= `OSAB_ADC_VAS_LO && code_in <= `OSAB_ADC_VAS_HI)
            lock_class_out = `OSAB_LOCK_VAS;
        else
            lock_class_out = `OSAB_LOCK_LOCKED;
    end

    // pump current table
    always @*
    begin
        if (code_in < `OSAB_ADC_CP01)
            pump_auto_out = `OSAB_CP_00;
        else if (code_in == `OSAB_ADC_CP01)
            pump_auto_out = `OSAB_CP_01;
        else if (code_in == `OSAB_ADC_CP10)
            pump_auto_out = `OSAB_CP_10;
        else
            pump_auto_out = `OSAB_CP_11;
    end
endmodule // osab_adc_class

// [logic/osab_top.v]
// oscillator band autoselect control with avalon register slave
// Summary of operation
// - four oscillators, eight sub-bands; manual fields select them when search is off
// - with autoselect enabled, writing the low divider word starts a search
// - search starts from the manual oscillator and sub-band fields
// - search-inactive flag held clear while searching
// - success sets inactive and success flags, reports chosen band in status two
// - failed search clears success and sets inactive
// - search accepts a band only for adc codes 010 through 101
// - codes 000/111 out of lock, next inward locked, middle search-locked
// - pump follows adc if auto pump and (search off or success), else programmed
// - auto pump: 000-010 gives 00, 011 01, 100 10, 101 up 11
// - pump setting in effect shown in status byte one
// - adc converts only while its enable bit is set
// - writing latch bit as one captures the conversion into status two
// - detector enable switches detector; attack field sets threshold
// - detector output current mode by default, voltage when diagnostic field is 100
// - injection bit: one high side (default), zero low side
// - quadrature disable bit turns off the q channel
// - filter source set uses factory trim, clear uses tune field
// - status two: oscillator 7:6, sub-band 5:3, adc 2:0
// - status one: pump 4:3, success bit 1, inactive bit 0
`timescale 1ns/1ps
`include "osab_defs.vh"
module osab_top
(
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire [3:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    input  wire [2:0]  tune_adc_code_in,
    output reg  [1:0]  oscillator_core_out,
    output reg  [2:0]  oscillator_subband_out,
    output reg  [1:0]  pump_current_out,
    output reg  [1:0]  lock_class_out,
    output reg         tune_adc_enable_out,
    output reg         detector_enable_out,
    output reg  [2:0]  detector_attack_point_out,
    output reg         detector_voltage_mode_out,
    output reg         injection_high_side_out,
    output reg         quadrature_disable_out,
    output reg         filter_factory_trim_out,
    output reg  [2:0]  filter_tune_code_out,
    output reg         baseband_gain_step_out,
    output reg         search_active_out
);
    // search controller states
    localparam ST_IDLE  = 2'h0;
    localparam ST_WAIT  = 2'h1;
    localparam ST_CHECK = 2'h2;

    // host-writable registers
    reg  [7:0] osc_q;
    reg  [7:0] pll_q;
    reg  [7:0] ctrl_q;
    reg  [7:0] test_q;
    reg  [7:0] xdiv_q;
    reg  [7:0] divref_q;
    reg  [7:0] divhi_q;
    reg  [7:0] divlo_q;

    // latched converter code and search datapath
    reg  [2:0] adc_latch_q;
    reg        succ_q;
    reg        inact_q;
    reg  [1:0] st_q;
    reg  [1:0] core_q;
    reg  [2:0] sub_q;
    reg  [7:0] wait_q;
    reg  [5:0] steps_q;

    // bus handshake and read mux
    reg        ack_q;
    reg  [7:0] rdata_d;

    // converter, classifier and bus strobes
    wire [2:0] adc_now;
    wire [1:0] cls_now;
    wire [1:0] pump_auto;
    wire [1:0] pump_eff;
    wire       wr_cyc;
    wire       wr_lo;
    wire       start;
    wire       searching;
    wire [7:0] stat1_w;
    wire [7:0] stat2_w;

    // converter output is zero when disabled
    assign adc_now = osc_q[`OSAB_OSC_ADE] ? tune_adc_code_in : `OSAB_ADC_MIN;

    osab_adc_class u_class
    (
        .code_in        (adc_now),
        .lock_class_out (cls_now),
        .pump_auto_out  (pump_auto)
    );

    // bus strobes; one wait cycle then ack
    assign wr_cyc = avs_write_in & ack_q;
    assign wr_lo  = wr_cyc & avs_byteenable_in[0];
    assign start  = wr_lo & (avs_address_in == `OSAB_ADDR_DIVLO)
                    & pll_q[`OSAB_PLL_VAS];
    assign searching = (st_q != ST_IDLE);

    // pump selection
    assign pump_eff = (pll_q[`OSAB_PLL_CPS] & (~pll_q[`OSAB_PLL_VAS] | succ_q))
                      ? pump_auto
                      : pll_q[`OSAB_PLL_CP_HI:`OSAB_PLL_CP_LO];

    // status bytes as the host reads them
    assign stat1_w = {3'h0, pump_eff, 1'b0, succ_q, inact_q};
    assign stat2_w = {core_q, sub_q, adc_latch_q};

    // handshake: waitrequest high until the ack cycle
    always @(posedge clk_in)
    begin
        if (rst_in)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
    end

    // writable registers
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            osc_q    <= `OSAB_RST_OSC;
            pll_q    <= `OSAB_RST_PLL;
            ctrl_q   <= `OSAB_RST_CTRL;
            test_q   <= `OSAB_RST_TEST;
            xdiv_q   <= `OSAB_RST_XDIV;
            divref_q <= `OSAB_RST_DIVREF;
            divhi_q  <= `OSAB_RST_DIVHI;
            divlo_q  <= `OSAB_RST_DIVLO;
        end
        else if (wr_lo)
        begin
            case (avs_address_in)
                `OSAB_ADDR_OSC:    osc_q    <= avs_writedata_in[7:0];
                `OSAB_ADDR_PLL:    pll_q    <= avs_writedata_in[7:0];
                `OSAB_ADDR_CTRL:   ctrl_q   <= avs_writedata_in[7:0];
                `OSAB_ADDR_TEST:   test_q   <= avs_writedata_in[7:0];
                `OSAB_ADDR_XDIV:   xdiv_q   <= avs_writedata_in[7:0];
                `OSAB_ADDR_DIVREF: divref_q <= avs_writedata_in[7:0];
                `OSAB_ADDR_DIVHI:  divhi_q  <= avs_writedata_in[7:0];
                `OSAB_ADDR_DIVLO:  divlo_q  <= avs_writedata_in[7:0];
                default:           osc_q    <= osc_q;
            endcase
        end
    end

    // adc latch capture on latch-bit write, held otherwise
    always @(posedge clk_in)
    begin
        if (rst_in)
            adc_latch_q <= `OSAB_ADC_MIN;
        else if (wr_lo && avs_address_in == `OSAB_ADDR_OSC
                 && avs_writedata_in[`OSAB_OSC_ADL])
            adc_latch_q <= adc_now;
        else
            adc_latch_q <= adc_latch_q;
    end

    // search state machine
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_q    <= ST_IDLE;
            core_q  <= 2'h0;
            sub_q   <= 3'h0;
            wait_q  <= 8'h00;
            steps_q <= 6'h00;
            succ_q  <= 1'b0;
            inact_q <= 1'b1;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    // manual selection follows the fields while autoselect is off
                    if (!pll_q[`OSAB_PLL_VAS])
                    begin
                        core_q <= osc_q[`OSAB_OSC_CORE_HI:`OSAB_OSC_CORE_LO];
                        sub_q  <= osc_q[`OSAB_OSC_SUB_HI:`OSAB_OSC_SUB_LO];
                        succ_q <= 1'b0;
                    end
                    if (start)
                    begin
                        core_q  <= osc_q[`OSAB_OSC_CORE_HI:`OSAB_OSC_CORE_LO];
                        sub_q   <= osc_q[`OSAB_OSC_SUB_HI:`OSAB_OSC_SUB_LO];
                        wait_q  <= `OSAB_SETTLE_CYC;
                        steps_q <= 6'h00;
                        succ_q  <= 1'b0;
                        inact_q <= 1'b0;
                        st_q    <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    // a new low-word write restarts from the manual fields
                    if (start)
                    begin
                        core_q  <= osc_q[`OSAB_OSC_CORE_HI:`OSAB_OSC_CORE_LO];
                        sub_q   <= osc_q[`OSAB_OSC_SUB_HI:`OSAB_OSC_SUB_LO];
                        wait_q  <= `OSAB_SETTLE_CYC;
                        steps_q <= 6'h00;
                    end
                    else if (wait_q == 8'h00)
                        st_q <= ST_CHECK;
                    else
                        wait_q <= wait_q - 8'h01;
                end
                ST_CHECK:
                begin
                    // a write landing on the check cycle must not be lost
                    if (start)
                    begin
                        core_q  <= osc_q[`OSAB_OSC_CORE_HI:`OSAB_OSC_CORE_LO];
                        sub_q   <= osc_q[`OSAB_OSC_SUB_HI:`OSAB_OSC_SUB_LO];
                        wait_q  <= `OSAB_SETTLE_CYC;
                        steps_q <= 6'h00;
                        st_q    <= ST_WAIT;
                    end
                    // accept only the search-locked codes
                    else if (adc_now >= `OSAB_ADC_VAS_LO && adc_now <= `OSAB_ADC_VAS_HI)
                    begin
                        succ_q  <= 1'b1;
                        inact_q <= 1'b1;
                        st_q    <= ST_IDLE;
                    end
                    // last band tried without a usable code
                    else if (steps_q == `OSAB_STEPS_MAX - 6'h01)
                    begin
                        succ_q  <= 1'b0;
                        inact_q <= 1'b1;
                        st_q    <= ST_IDLE;
                    end
                    else
                    begin
                        // step to next sub-band, wrapping into next core
                        {core_q, sub_q} <= {core_q, sub_q} + 5'h01;
                        steps_q <= steps_q + 6'h01;
                        wait_q  <= `OSAB_SETTLE_CYC;
                        st_q    <= ST_WAIT;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // read data mux
    always @*
    begin
        case (avs_address_in)
            `OSAB_ADDR_OSC:    rdata_d = osc_q;
            `OSAB_ADDR_PLL:    rdata_d = pll_q;
            `OSAB_ADDR_DIVLO:  rdata_d = divlo_q;
            `OSAB_ADDR_CTRL:   rdata_d = ctrl_q;
            `OSAB_ADDR_TEST:   rdata_d = test_q;
            `OSAB_ADDR_XDIV:   rdata_d = xdiv_q;
            `OSAB_ADDR_STAT1:  rdata_d = stat1_w;
            `OSAB_ADDR_STAT2:  rdata_d = stat2_w;
            `OSAB_ADDR_DIVREF: rdata_d = divref_q;
            `OSAB_ADDR_DIVHI:  rdata_d = divhi_q;
            default:           rdata_d = 8'h00;
        endcase
    end

    // bus outputs registered
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            avs_readdata_out    <= 32'h0000_0000;
            avs_waitrequest_out <= 1'b1;
        end
        else
        begin
            avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack_q);
            if (avs_read_in & ~ack_q)
                avs_readdata_out <= {24'h00_0000, rdata_d};
        end
    end

    // band, pump and lock class outputs
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            oscillator_core_out       <= 2'h0;
            oscillator_subband_out    <= 3'h0;
            pump_current_out          <= `OSAB_CP_00;
            lock_class_out            <= `OSAB_LOCK_OUT;
        end
        else
        begin
            oscillator_core_out       <= core_q;
            oscillator_subband_out    <= sub_q;
            pump_current_out          <= pump_eff;
            lock_class_out            <= cls_now;
        end
    end

    // register mirrors to the analog controls, and the search flag
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            tune_adc_enable_out       <= 1'b0;
            detector_enable_out       <= 1'b0;
            detector_attack_point_out <= 3'h0;
            detector_voltage_mode_out <= 1'b0;
            injection_high_side_out   <= 1'b1;
            quadrature_disable_out    <= 1'b0;
            filter_factory_trim_out   <= 1'b1;
            filter_tune_code_out      <= 3'h0;
            baseband_gain_step_out    <= 1'b0;
            search_active_out         <= 1'b0;
        end
        else
        begin
            tune_adc_enable_out       <= osc_q[`OSAB_OSC_ADE];
            detector_enable_out       <= ctrl_q[`OSAB_CTRL_EPD];
            detector_attack_point_out <= ctrl_q[`OSAB_CTRL_PD_HI:`OSAB_CTRL_PD_LO];
            detector_voltage_mode_out <= (test_q[`OSAB_TEST_D_HI:`OSAB_TEST_D_LO]
                                          == `OSAB_DIAG_VOLT);
            injection_high_side_out   <= ctrl_q[`OSAB_CTRL_INJECTION_SIDE_SELECT];
            quadrature_disable_out    <= xdiv_q[`OSAB_XDIV_QUADRATURE_DISABLE];
            filter_factory_trim_out   <= test_q[`OSAB_TEST_FILTER_TRIM_SOURCE];
            filter_tune_code_out      <= test_q[`OSAB_TEST_TUN_HI:`OSAB_TEST_TUN_LO];
            baseband_gain_step_out    <= ctrl_q[`OSAB_CTRL_MOD];
            search_active_out         <= searching;
        end
    end
endmodule // osab_top

// [verif/osab_top_monitor.sv]
// port-level checks for the oscillator band autoselect block
`timescale 1ns/1ps
`include "osab_defs.vh"
module osab_top_monitor
(
    input wire        clk_in,
    input wire        rst_in,
    input wire [3:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0]  avs_byteenable_in,
    input wire        avs_waitrequest_out,
    input wire [2:0]  tune_adc_code_in,
    input wire [1:0]  lock_class_out,
    input wire        tune_adc_enable_out,
    input wire        detector_enable_out,
    input wire [2:0]  detector_attack_point_out,
    input wire        detector_voltage_mode_out,
    input wire        injection_high_side_out,
    input wire        quadrature_disable_out,
    input wire        filter_factory_trim_out,
    input wire [2:0]  filter_tune_code_out,
    input wire        baseband_gain_step_out,
    input wire        search_active_out
);
    // write data slices, taken two edges before the mirrored output
    wire [2:0] w_hi = avs_writedata_in[7:5];
    wire [2:0] w_lo = avs_writedata_in[2:0];
    wire       w_b3 = avs_writedata_in[3];
    wire       w_b2 = avs_writedata_in[2];
    wire       w_b0 = avs_writedata_in[0];
    wire       acc  = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    wire       w_lo_div = acc && avs_address_in == `OSAB_ADDR_DIVLO;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    function automatic logic [1:0] cls(input logic [2:0] c);
        cls = (c == 3'h0 || c == 3'h7) ? 2'h0 : (c == 3'h1 || c == 3'h6) ? 2'h1 : 2'h2;
    endfunction
    chk_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("request not answered next cycle");
    chk_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    chk_ctrl_mirror: assert property (acc && avs_address_in == `OSAB_ADDR_CTRL |=> ##1
        {detector_enable_out, injection_high_side_out, baseband_gain_step_out} == $past(w_hi, 2)
        && detector_attack_point_out == $past(w_lo, 2)) else $error("control pins wrong");
    chk_test_mirror: assert property (acc && avs_address_in == `OSAB_ADDR_TEST |=> ##1
        detector_voltage_mode_out == ($past(w_hi, 2) == `OSAB_DIAG_VOLT)
        && filter_factory_trim_out == $past(w_b3, 2) && filter_tune_code_out == $past(w_lo, 2))
        else $error("test pins wrong");
    chk_qdis_mirror: assert property (acc && avs_address_in == `OSAB_ADDR_XDIV |=> ##1
        quadrature_disable_out == $past(w_b0, 2)) else $error("q disable wrong");
    chk_adc_enable: assert property (acc && avs_address_in == `OSAB_ADDR_OSC |=> ##1
        tune_adc_enable_out == $past(w_b2, 2)) else $error("adc enable wrong");
    chk_lock_class: assert property ($stable(tune_adc_code_in)[*3] |->
        lock_class_out == cls(tune_adc_code_in)) else $error("lock class wrong");
    chk_search_cause: assert property ($rose(search_active_out) |->
        $past(w_lo_div) || $past(w_lo_div, 2)) else $error("search started without trigger");
    chk_search_bound: assert property ($rose(search_active_out) |->
        ##[1:1000] !search_active_out) else $error("search never ends");
    cover property (w_lo_div ##[1:3] $rose(search_active_out));
    cover property ($fell(search_active_out));
    cover property (lock_class_out == `OSAB_LOCK_VAS);
endmodule // osab_top_monitor
bind osab_top osab_top_monitor u_osab_top_monitor (.*);

// [verif/osab_adc_model.sv]
// tuning converter model: hit code on the target band, miss code elsewhere
`timescale 1ns/1ps
module osab_adc_model
(
    input  wire       enable_in,
    input  wire [1:0] core_in,
    input  wire [2:0] sub_in,
    input  wire [5:0] target_in,
    input  wire [2:0] hit_code_in,
    input  wire [2:0] miss_code_in,
    output wire [2:0] code_out
);
    // converter rests at zero while disabled
    assign code_out = !enable_in ? 3'h0 :
        ({1'b0, core_in, sub_in} == target_in) ? hit_code_in : miss_code_in;
endmodule // osab_adc_model

// [verif/osab_top_test.sv]
// register-level tests of the oscillator band autoselect block
`timescale 1ns/1ps
`include "osab_defs.vh"
module osab_top_test;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [3:0]  avs_address_in = 4'h0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'h1;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic [2:0]  tune_adc_code_in;
    logic [1:0]  oscillator_core_out, pump_current_out, lock_class_out;
    logic [2:0]  oscillator_subband_out, detector_attack_point_out, filter_tune_code_out;
    logic        tune_adc_enable_out, detector_enable_out, detector_voltage_mode_out;
    logic        injection_high_side_out, quadrature_disable_out, filter_factory_trim_out;
    logic        baseband_gain_step_out, search_active_out;
    logic [5:0]  target_q = 6'h0;
    logic [2:0]  hit_q = 3'h0;
    logic [2:0]  miss_q = 3'h7;
    logic [31:0] rdata;
    logic [1:0]  e_cls, e_pmp;
    int          err_total = 0;
    int          samples_checked = 0;
    int          i;
    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;
    osab_top u_osab_top (.*);
    osab_adc_model u_osab_adc_model (.enable_in(tune_adc_enable_out),
        .core_in(oscillator_core_out), .sub_in(oscillator_subband_out), .target_in(target_q),
        .hit_code_in(hit_q), .miss_code_in(miss_q), .code_out(tune_adc_code_in));
    task automatic print_verdict;
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic r, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] b);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, d};
        avs_byteenable_in <= b;
        avs_read_in <= r;
        avs_write_in <= !r;
        @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0)
            @(posedge clk_in);
        rdata = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b0, a, d, 4'h1);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        bus(1'b1, a, 8'h00, 4'h1);
        samples_checked++;
        if (rdata !== {24'h0, e})
        begin
            err_total++;
            $display("[FAIL] t=%0t read=%h exp=%h", $time, rdata, e);
        end
    endtask
    task automatic cmp_pin(input logic [7:0] got, input logic [7:0] e);
        samples_checked++;
        if (got !== e)
        begin
            err_total++;
            $display("[FAIL] t=%0t pin=%h exp=%h", $time, got, e);
        end
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task automatic wait_idle;
        repeat (2) @(posedge clk_in);
        #1;
        for (i = 0; i < 1500 && search_active_out !== 1'b0; i++)
            @(posedge clk_in);
        #1;
        if (i >= 1500)
        begin
            err_total++;
            print_verdict;
        end
    endtask
    // watchdog against a hung handshake or search
    initial
    begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        print_verdict;
    end
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        rdc(`OSAB_ADDR_STAT1, 8'h01);
        rdc(`OSAB_ADDR_STAT2, 8'h00);
        rdc(`OSAB_ADDR_CTRL, `OSAB_RST_CTRL);
        rdc(`OSAB_ADDR_TEST, `OSAB_RST_TEST);
        cmp_pin({6'h0, injection_high_side_out, filter_factory_trim_out}, 8'h03);
        wr(4'ha, 8'hff);
        rdc(4'ha, 8'h00);
        wr(`OSAB_ADDR_CTRL, 8'ha5);
        bus(1'b0, `OSAB_ADDR_CTRL, 8'h40, 4'h0);
        settle;
        cmp_pin({2'h0, detector_enable_out, injection_high_side_out, baseband_gain_step_out,
                 detector_attack_point_out}, 8'h2d);
        wr(`OSAB_ADDR_TEST, 8'h80);
        settle;
        cmp_pin({2'h0, detector_voltage_mode_out, filter_factory_trim_out, 1'b0,
                 filter_tune_code_out}, 8'h20);
        wr(`OSAB_ADDR_TEST, 8'h6f);
        settle;
        cmp_pin({2'h0, detector_voltage_mode_out, filter_factory_trim_out, 1'b0,
                 filter_tune_code_out}, 8'h17);
        wr(`OSAB_ADDR_XDIV, 8'h01);
        settle;
        cmp_pin({7'h0, quadrature_disable_out}, 8'h01);
        wr(`OSAB_ADDR_OSC, 8'hac);
        settle;
        cmp_pin({2'h0, tune_adc_enable_out, oscillator_core_out, oscillator_subband_out},
                8'h35);
        rdc(`OSAB_ADDR_STAT2, 8'ha8);
        // every converter code latched, classed and mapped to a pump setting
        target_q <= 6'd21;
        wr(`OSAB_ADDR_PLL, 8'h40);
        for (int c = 0; c < 8; c++)
        begin
            @(posedge clk_in);
            hit_q <= c[2:0];
            e_cls = (c == 0 || c == 7) ? 2'h0 : (c == 1 || c == 6) ? 2'h1 : 2'h2;
            e_pmp = (c <= 2) ? 2'h0 : (c == 3) ? 2'h1 : (c == 4) ? 2'h2 : 2'h3;
            wr(`OSAB_ADDR_OSC, 8'hae);
            settle;
            rdc(`OSAB_ADDR_STAT2, {5'h15, c[2:0]});
            cmp_pin({4'h0, lock_class_out, pump_current_out}, {4'h0, e_cls, e_pmp});
            rdc(`OSAB_ADDR_STAT1, {3'h0, e_pmp, 3'h1});
        end
        @(posedge clk_in);
        hit_q <= 3'h2;
        settle;
        rdc(`OSAB_ADDR_STAT2, 8'haf);
        wr(`OSAB_ADDR_PLL, 8'h30);
        settle;
        cmp_pin({6'h0, pump_current_out}, 8'h03);
        wr(`OSAB_ADDR_PLL, 8'he0);
        wr(`OSAB_ADDR_DIVHI, 8'h53);
        wr(`OSAB_ADDR_DIVREF, 8'h38);
        settle;
        cmp_pin({5'h0, search_active_out, pump_current_out}, 8'h02);
        // search from band 0 to band 13, edge codes 5 accepted and 6 refused
        wr(`OSAB_ADDR_OSC, 8'h04);
        @(posedge clk_in);
        target_q <= 6'd13;
        hit_q <= 3'h5;
        miss_q <= 3'h6;
        wr(`OSAB_ADDR_PLL, 8'hc0);
        wr(`OSAB_ADDR_DIVLO, 8'hf8);
        @(posedge clk_in);
        #1;
        cmp_pin({7'h0, search_active_out}, 8'h01);
        rdc(`OSAB_ADDR_STAT1, 8'h00);
        wait_idle;
        rdc(`OSAB_ADDR_STAT1, 8'h1b);
        rdc(`OSAB_ADDR_STAT2, 8'h6f);
        cmp_pin({3'h0, oscillator_core_out, oscillator_subband_out}, 8'h0d);
        // unreachable band ends in failure
        @(posedge clk_in);
        target_q <= 6'd40;
        wr(`OSAB_ADDR_DIVLO, 8'hf8);
        wr(`OSAB_ADDR_DIVLO, 8'hf8);
        wait_idle;
        rdc(`OSAB_ADDR_STAT1, 8'h01);
        print_verdict;
    end
endmodule // osab_top_test
